// File: verilog/bridge_secondary_status_memwin.sv
// secondary status upper half, memory window base/limit, parity response enable and interrupt
// assumes a classic wishbone master on clk_sys and event pulses synchronous to clk_sys
module bridge_secondary_status_memwin
	import bridge_regs_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wb_err_o,
	input wire sec_events_s events,
	output mem_window_s mem_window,
	output logic parity_resp_en,
	output logic irq
);
	typedef enum logic [0:0] { BUS_IDLE, BUS_ACK } bus_state_e;

	bus_state_e state_reg;
	bus_state_e state_next;
	logic ack_reg;
	logic ack_next;
	logic err_reg;
	logic err_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic [11:0] mem_base_reg;
	logic [11:0] mem_base_next;
	logic [11:0] mem_limit_reg;
	logic [11:0] mem_limit_next;
	logic perr_resp_reg;
	logic perr_resp_next;
	logic [NUM_FLAGS-1:0] irq_mask_reg;
	logic [NUM_FLAGS-1:0] irq_mask_next;
	logic [NUM_FLAGS-1:0] flag_set;
	logic [NUM_FLAGS-1:0] flag_clear;
	logic [NUM_FLAGS-1:0] flags;
	logic [31:0] status_word;
	logic [31:0] memwin_word;
	logic req;
	logic wr_take;
	logic mapped;

	// a request is taken on the first cycle of a strobe; ack follows one cycle later
	// a strobe still high in the ack cycle is not taken again, because the answer state blocks it
	assign req = wb_cyc_i & wb_stb_i & (state_reg == BUS_IDLE);
	assign wr_take = req & wb_we_i;
	assign mapped = (wb_adr_i == ADDR_STATUS) | (wb_adr_i == ADDR_MEMWIN) | (wb_adr_i == ADDR_BRCTL)
		| (wb_adr_i == ADDR_IRQ_MASK) | (wb_adr_i == ADDR_IRQ_STAT);

	// event sources gathered into the sticky vector
	always_comb
	begin
		flag_set = '0;
		flag_set[FLAG_MDPERR] = perr_resp_reg & (events.read_data_perr | events.write_perr_seen
			| events.split_write_perr);
		flag_set[FLAG_SIG_TABORT] = events.target_abort_sent;
		flag_set[FLAG_RCV_TABORT] = events.target_abort_rcvd;
		flag_set[FLAG_RCV_MABORT] = events.master_abort_rcvd;
		flag_set[FLAG_RCV_SERR] = events.serr_seen;
		flag_set[FLAG_DET_PERR] = events.addr_data_perr;
	end

	// write-one-to-clear from either the status word (top byte lane) or the interrupt status word
	always_comb
	begin
		flag_clear = '0;
		if (wr_take && wb_adr_i == ADDR_STATUS)
		begin
			flag_clear[FLAG_MDPERR] = wb_sel_i[3] & wb_dat_i[BIT_MDPERR];
			flag_clear[FLAG_SIG_TABORT] = wb_sel_i[3] & wb_dat_i[BIT_SIG_TABORT];
			flag_clear[FLAG_RCV_TABORT] = wb_sel_i[3] & wb_dat_i[BIT_RCV_TABORT];
			flag_clear[FLAG_RCV_MABORT] = wb_sel_i[3] & wb_dat_i[BIT_RCV_MABORT];
			flag_clear[FLAG_RCV_SERR] = wb_sel_i[3] & wb_dat_i[BIT_RCV_SERR];
			flag_clear[FLAG_DET_PERR] = wb_sel_i[3] & wb_dat_i[BIT_DET_PERR];
		end
		else if (wr_take && wb_adr_i == ADDR_IRQ_STAT && wb_sel_i[0])
			flag_clear = wb_dat_i[NUM_FLAGS-1:0];
	end

	sticky_flags #(
		.WIDTH(NUM_FLAGS)
	) u_flags (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.set(flag_set),
		.clear(flag_clear),
		.flags(flags)
	);

	// status word: low half belongs to other logic and reads zero here
	always_comb
	begin
		status_word = '0;
		status_word[BIT_66MHZ] = RST_66MHZ;
		status_word[BIT_FB2B] = RST_FB2B;
		status_word[BIT_MDPERR] = flags[FLAG_MDPERR];
		status_word[BIT_DEVSEL_LO+1:BIT_DEVSEL_LO] = DEVSEL_MEDIUM;
		status_word[BIT_SIG_TABORT] = flags[FLAG_SIG_TABORT];
		status_word[BIT_RCV_TABORT] = flags[FLAG_RCV_TABORT];
		status_word[BIT_RCV_MABORT] = flags[FLAG_RCV_MABORT];
		status_word[BIT_RCV_SERR] = flags[FLAG_RCV_SERR];
		status_word[BIT_DET_PERR] = flags[FLAG_DET_PERR];
	end

	// reserved nibbles read as zero
	assign memwin_word = {mem_limit_reg, 4'h0, mem_base_reg, 4'h0};

	// register writes honour byte lanes; a field split across lanes updates lane by lane
	always_comb
	begin
		mem_base_next = mem_base_reg;
		mem_limit_next = mem_limit_reg;
		perr_resp_next = perr_resp_reg;
		irq_mask_next = irq_mask_reg;
		if (wr_take && wb_adr_i == ADDR_MEMWIN)
		begin
			if (wb_sel_i[0])
				mem_base_next[3:0] = wb_dat_i[7:4];
			if (wb_sel_i[1])
				mem_base_next[11:4] = wb_dat_i[15:8];
			if (wb_sel_i[2])
				mem_limit_next[3:0] = wb_dat_i[23:20];
			if (wb_sel_i[3])
				mem_limit_next[11:4] = wb_dat_i[31:24];
		end
		if (wr_take && wb_adr_i == ADDR_BRCTL && wb_sel_i[2])
			perr_resp_next = wb_dat_i[BIT_PERR_RESP];
		if (wr_take && wb_adr_i == ADDR_IRQ_MASK && wb_sel_i[0])
			irq_mask_next = wb_dat_i[NUM_FLAGS-1:0];
	end

	// bus answer: one ack per request, err for unmapped addresses, read data registered
	always_comb
	begin
		state_next = state_reg;
		ack_next = 1'b0;
		err_next = 1'b0;
		rdata_next = rdata_reg;
		case (state_reg)
			BUS_IDLE:
			begin
				if (req)
				begin
					state_next = BUS_ACK;
					ack_next = mapped;
					err_next = ~mapped;
					rdata_next = '0;
					if (!wb_we_i)
					begin
						case (wb_adr_i)
							ADDR_STATUS: rdata_next = status_word;
							ADDR_MEMWIN: rdata_next = memwin_word;
							ADDR_BRCTL: rdata_next = {15'h0000, perr_resp_reg, 16'h0000};
							ADDR_IRQ_MASK: rdata_next = {{(32-NUM_FLAGS){1'b0}}, irq_mask_reg};
							ADDR_IRQ_STAT: rdata_next = {{(32-NUM_FLAGS){1'b0}}, flags};
							default: rdata_next = '0;
						endcase
					end
				end
			end
			BUS_ACK:
			begin
				// one idle cycle lets the master drop stb before a new request is seen
				state_next = BUS_IDLE;
			end
			default: state_next = BUS_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state_reg <= BUS_IDLE;
			ack_reg <= 1'b0;
			err_reg <= 1'b0;
			rdata_reg <= '0;
			mem_base_reg <= RST_MEM_BASE;
			mem_limit_reg <= RST_MEM_LIMIT;
			perr_resp_reg <= 1'b0;
			irq_mask_reg <= '0;
		end
		else
		begin
			state_reg <= state_next;
			ack_reg <= ack_next;
			err_reg <= err_next;
			rdata_reg <= rdata_next;
			mem_base_reg <= mem_base_next;
			mem_limit_reg <= mem_limit_next;
			perr_resp_reg <= perr_resp_next;
			irq_mask_reg <= irq_mask_next;
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_err_o = err_reg;
	assign wb_dat_o = rdata_reg;
	assign parity_resp_en = perr_resp_reg;
	// one driver for the whole window; the limit's low bits are ones so it names the last byte of its megabyte
	assign mem_window = {mem_base_reg, 20'h00000, mem_limit_reg, LIMIT_LOW_ONES};
	// level interrupt while any unmasked flag stands
	assign irq = |(flags & irq_mask_reg);

	// event recording: each source shows in its flag one cycle after it is seen, the master parity sources only while parity response is enabled
	a_mdperr_gated: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(!perr_resp_reg && !flags[FLAG_MDPERR]) |=> !flags[FLAG_MDPERR])
		else $error("master data parity flag set while response disabled");
	a_mdperr_sources: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(perr_resp_reg && (events.read_data_perr || events.write_perr_seen || events.split_write_perr))
		|=> flags[FLAG_MDPERR])
		else $error("master data parity event not recorded");
	a_sig_tabort: assert property (@(posedge clk_sys) disable iff (!reset_n)
		events.target_abort_sent |=> status_word[BIT_SIG_TABORT])
		else $error("signalled target abort not recorded");
	a_rcv_tabort: assert property (@(posedge clk_sys) disable iff (!reset_n)
		events.target_abort_rcvd |=> status_word[BIT_RCV_TABORT])
		else $error("received target abort not recorded");
	a_rcv_mabort: assert property (@(posedge clk_sys) disable iff (!reset_n)
		events.master_abort_rcvd |=> status_word[BIT_RCV_MABORT])
		else $error("received master abort not recorded");
	a_rcv_serr: assert property (@(posedge clk_sys) disable iff (!reset_n)
		events.serr_seen |=> status_word[BIT_RCV_SERR])
		else $error("system error not recorded");
	a_det_perr: assert property (@(posedge clk_sys) disable iff (!reset_n)
		events.addr_data_perr |=> status_word[BIT_DET_PERR])
		else $error("detected parity error not recorded");
	a_det_ungated: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(events.addr_data_perr && !perr_resp_reg) |=> flags[FLAG_DET_PERR])
		else $error("detected parity error held back by the enable");
	// fixed fields and the window as software reads them over the bus, window and bridge control writes
	a_fixed_bits: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(wb_ack_o && $past(wb_adr_i) == ADDR_STATUS && !$past(wb_we_i))
		|-> (wb_dat_o[26:25] == 2'b01 && wb_dat_o[23:21] == 3'b101 && wb_dat_o[20:0] == 21'h00000))
		else $error("fixed status bits wrong");
	a_memwin_rsvd: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(wb_ack_o && $past(wb_adr_i) == ADDR_MEMWIN && !$past(wb_we_i))
		|-> (wb_dat_o[19:16] == 4'h0 && wb_dat_o[3:0] == 4'h0))
		else $error("reserved window bits not zero");
	a_base_write: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(wr_take && wb_adr_i == ADDR_MEMWIN && wb_sel_i == 4'hf)
		|=> (mem_base_reg == $past(wb_dat_i[15:4]) && mem_limit_reg == $past(wb_dat_i[31:20])))
		else $error("memory window write lost");
	a_base_lane_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(wr_take && wb_adr_i == ADDR_MEMWIN && !wb_sel_i[1]) |=> $stable(mem_base_reg[11:4]))
		else $error("memory base changed through a disabled lane");
	a_limit_lane_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(wr_take && wb_adr_i == ADDR_MEMWIN && !wb_sel_i[3]) |=> $stable(mem_limit_reg[11:4]))
		else $error("memory limit changed through a disabled lane");
	a_brctl_write: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(wr_take && wb_adr_i == ADDR_BRCTL && wb_sel_i[2])
		|=> (parity_resp_en == $past(wb_dat_i[BIT_PERR_RESP])))
		else $error("parity response enable write lost");
	// software clears and bus behaviour
	a_clear_w1c: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(flag_clear[FLAG_DET_PERR] && !flag_set[FLAG_DET_PERR]) |=> !flags[FLAG_DET_PERR])
		else $error("write one did not clear flag");
	a_clear_status_view: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(wr_take && wb_adr_i == ADDR_STATUS && wb_sel_i[3] && wb_dat_i[BIT_RCV_SERR]
		&& !flag_set[FLAG_RCV_SERR]) |=> !flags[FLAG_RCV_SERR])
		else $error("status word write did not clear flag");
	a_zero_keeps: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(wr_take && wb_adr_i == ADDR_STATUS && !wb_dat_i[BIT_DET_PERR] && flags[FLAG_DET_PERR])
		|=> flags[FLAG_DET_PERR])
		else $error("written zero cleared a flag");
	a_mask_write: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(wr_take && wb_adr_i == ADDR_IRQ_MASK && wb_sel_i[0])
		|=> (irq_mask_reg == $past(wb_dat_i[NUM_FLAGS-1:0])))
		else $error("interrupt mask write lost");
	a_ack_once: assert property (@(posedge clk_sys) disable iff (!reset_n)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held for two cycles");
	a_ack_err_excl: assert property (@(posedge clk_sys) disable iff (!reset_n)
		!(wb_ack_o && wb_err_o))
		else $error("ack and err raised together");
	a_err_unmapped: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(req && !mapped) |=> (wb_err_o && !wb_ack_o && wb_dat_o == 32'h00000000))
		else $error("unmapped request not refused");
	a_write_data_zero: assert property (@(posedge clk_sys) disable iff (!reset_n)
		((wb_ack_o || wb_err_o) && $past(wb_we_i)) |-> (wb_dat_o == 32'h00000000))
		else $error("read data not zero on a write answer");

	c_abort_irq: cover property (@(posedge clk_sys) disable iff (!reset_n) events.master_abort_rcvd ##1 irq);
	c_mdperr: cover property (@(posedge clk_sys) disable iff (!reset_n) $rose(flags[FLAG_MDPERR]));
	c_unmapped: cover property (@(posedge clk_sys) disable iff (!reset_n) wb_err_o);
	c_clear_race: cover property (@(posedge clk_sys) disable iff (!reset_n) |(flag_set & flag_clear));
	c_window_write: cover property (@(posedge clk_sys) disable iff (!reset_n)
		wr_take && wb_adr_i == ADDR_MEMWIN && wb_sel_i == 4'hf);
endmodule

// File: shared/bridge_regs_pkg.sv
// register map, field positions and reset values for the secondary status / memory window slice
// assumes a 32-bit classic wishbone slave and one core clock
package bridge_regs_pkg;
	// byte addresses of the 32-bit words
	localparam logic [7:0] ADDR_STATUS = 8'h1c;
	localparam logic [7:0] ADDR_MEMWIN = 8'h20;
	localparam logic [7:0] ADDR_BRCTL = 8'h3c;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h40;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h44;
	// status and bridge control bit positions, flag count
	localparam int BIT_66MHZ = 21;
	localparam int BIT_FB2B = 23;
	localparam int BIT_MDPERR = 24;
	localparam int BIT_DEVSEL_LO = 25;
	localparam int BIT_SIG_TABORT = 27;
	localparam int BIT_RCV_TABORT = 28;
	localparam int BIT_RCV_MABORT = 29;
	localparam int BIT_RCV_SERR = 30;
	localparam int BIT_DET_PERR = 31;
	localparam int BIT_PERR_RESP = 16;
	localparam int NUM_FLAGS = 6;
	// fixed values and memory window reset values
	localparam logic RST_66MHZ = 1'b1;
	localparam logic RST_FB2B = 1'b1;
	localparam logic [1:0] DEVSEL_MEDIUM = 2'h1;
	localparam logic [11:0] RST_MEM_BASE = 12'h000;
	localparam logic [11:0] RST_MEM_LIMIT = 12'h000;
	localparam logic [19:0] LIMIT_LOW_ONES = 20'hfffff;
	// flag index within the sticky vector
	localparam int FLAG_MDPERR = 0;
	localparam int FLAG_SIG_TABORT = 1;
	localparam int FLAG_RCV_TABORT = 2;
	localparam int FLAG_RCV_MABORT = 3;
	localparam int FLAG_RCV_SERR = 4;
	localparam int FLAG_DET_PERR = 5;

	// event strobes from the secondary-bus interface logic, one-cycle pulses
	typedef struct packed {
		logic read_data_perr;
		logic write_perr_seen;
		logic split_write_perr;
		logic target_abort_sent;
		logic target_abort_rcvd;
		logic master_abort_rcvd;
		logic serr_seen;
		logic addr_data_perr;
	} sec_events_s;

	// decoded memory window for the forwarding logic
	typedef struct packed {
		logic [31:0] base;
		logic [31:0] limit;
	} mem_window_s;
endpackage

// File: verilog/sticky_flags.sv
// bank of write-one-to-clear sticky flags
// assumes set and clear are one-cycle strobes in the clk_sys domain
module sticky_flags
	import bridge_regs_pkg::*;
#(
	parameter int WIDTH = 6
)
(
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic [WIDTH-1:0] set,
	input wire logic [WIDTH-1:0] clear,
	output logic [WIDTH-1:0] flags
);
	logic [WIDTH-1:0] flags_reg;
	logic [WIDTH-1:0] flags_next;

	// per bit: set wins over a clear in the same cycle
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_bit
			always_comb
			begin
				flags_next[i] = set[i] | (flags_reg[i] & ~clear[i]);
			end
		end
	endgenerate

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			flags_reg <= '0;
		else
			flags_reg <= flags_next;
	end

	assign flags = flags_reg;

	a_set_wins: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(set != '0) |=> ((flags & $past(set)) == $past(set)))
		else $error("sticky flag lost its set event");
endmodule

// File: dv/sec_bus_agent.sv
// behavioural stand-in for the agents on the secondary parallel bus
// assumes the bench requests events one cycle ahead on fire, all in the clk_sys domain
module sec_bus_agent
	import bridge_regs_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic [7:0] fire,
	output sec_events_s events
);
	timeunit 1ns;
	timeprecision 1ns;
	// each requested condition becomes a one-cycle strobe, as the bus interface logic would report it
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			events <= '0;
		else
			events <= fire;
	end
endmodule

// File: dv/tb.sv
// self-checking bench for the secondary status and memory window registers
// assumes the register slice answers every wishbone request one cycle after taking it
`define CHK(g, e, m) begin checked++; if ((g) !== (e)) begin fails++; $display("CHECK FAILED %0t %s", $time, m); end end
module tb
	import bridge_regs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys, reset_n, cyc, we, parity_resp_en, irq, wb_ack_o, wb_err_o, pre, e;
	logic [7:0] adr, fire;
	logic [3:0] sel;
	logic [31:0] dat, wb_dat_o, q, s, d;
	logic [5:0] flg, msk;
	logic [11:0] base, lim;
	sec_events_s events;
	mem_window_s mem_window;
	int fails, checked, cycles;

	bridge_secondary_status_memwin dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(cyc),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.wb_err_o(wb_err_o), .events(events), .mem_window(mem_window), .parity_resp_en(parity_resp_en), .irq(irq));
	sec_bus_agent agent_u (.clk_sys(clk_sys), .reset_n(reset_n), .fire(fire), .events(events));

	// flags that one event vector should raise; only the master parity flag is gated
	function automatic logic [5:0] ev_flags(logic [7:0] f, logic p);
		return {f[0], f[1], f[2], f[3], f[4], p & (|f[7:5])};
	endfunction

	// expected upper status half: fixed capability bits around the sticky flags
	function automatic logic [31:0] stat_word(logic [5:0] g);
		return {g[5:1], 2'b01, g[0], 1'b1, 1'b0, 1'b1, 5'h00, 16'h0000};
	endfunction

	task automatic conclude();
		$display("checked=%0d fails=%0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// one classic cycle; it waits for the answer as long as it takes, the cycle guard below ends a hang
	task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] b, input logic [31:0] v,
		output logic [31:0] r, output logic x);
		@(posedge clk_sys);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		sel <= b;
		dat <= v;
		do
		begin
			@(posedge clk_sys);
		end
		while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
		r = wb_dat_o;
		x = wb_err_o;
		cyc <= 1'b0;
		`CHK(wb_ack_o & wb_err_o, 1'b0, "ack and err together")
	endtask

	task automatic fire_ev(input logic [7:0] f);
		@(posedge clk_sys);
		fire <= f;
		@(posedge clk_sys);
		fire <= 8'h00;
	endtask

	task automatic check_state();
		wb(1'b0, ADDR_STATUS, 4'hf, 32'h0, q, e);
		`CHK(q, stat_word(flg), "status");
		wb(1'b0, ADDR_MEMWIN, 4'hf, 32'h0, q, e);
		`CHK(q, {lim, 4'h0, base, 4'h0}, "memwin");
		`CHK(mem_window, {base, 20'h00000, lim, 20'hfffff}, "window");
		wb(1'b0, ADDR_IRQ_STAT, 4'hf, 32'h0, q, e);
		`CHK(q, {26'h0, flg}, "irq status");
		`CHK(irq, |(flg & msk), "irq");
		`CHK(parity_resp_en, pre, "parity enable");
		wb(1'b0, ADDR_BRCTL, 4'hf, 32'h0, q, e);
		`CHK(q, {15'h0000, pre, 16'h0000}, "bridge control");
		wb(1'b0, ADDR_IRQ_MASK, 4'hf, 32'h0, q, e);
		`CHK(q, {26'h0, msk}, "irq mask");
	endtask

	initial
	begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	// hang guard, well above the some 1500 cycles the sequence needs
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			`CHK(1'b0, 1'b1, "timeout")
			conclude();
		end
	end

	initial
	begin
		{reset_n, cyc, we, adr, sel, dat, fire, flg, msk, pre, base, lim} = '0;
		{fails, checked, cycles} = '0;
		void'($urandom(82879));
		repeat (8) @(posedge clk_sys);
		reset_n <= 1'b1;
		check_state();
		// unmapped place is refused and changes nothing
		wb(1'b1, 8'h10, 4'hf, $urandom, q, e);
		`CHK({e, q}, 33'h100000000, "unmapped");
		// full-lane window write, both fields read back at once
		wb(1'b1, ADDR_MEMWIN, 4'hf, 32'hfed09870, q, e);
		{lim, base} = {12'hfed, 12'h987};
		check_state();
		// every event kind, with parity response off and on
		for (int p = 0; p < 2; p++)
		begin
			pre = p[0];
			wb(1'b1, ADDR_BRCTL, 4'h4, {15'h0, pre, 16'h0}, q, e);
			for (int k = 0; k < 8; k++)
			begin
				fire_ev(8'h01 << k);
				flg |= ev_flags(8'h01 << k, pre);
				check_state();
				wb(1'b1, ADDR_IRQ_STAT, 4'h1, 32'h3f, q, e);
				flg = '0;
			end
		end
		// random traffic
		for (int i = 0; i < 60; i++)
		begin
			s = $urandom;
			d = $urandom;
			case ($urandom_range(3))
				0:
				begin
					wb(1'b1, ADDR_MEMWIN, s[3:0], d, q, e);
					if (s[0]) base[3:0] = d[7:4];
					if (s[1]) base[11:4] = d[15:8];
					if (s[2]) lim[3:0] = d[23:20];
					if (s[3]) lim[11:4] = d[31:24];
				end
				1:
				begin
					fire_ev(d[7:0]);
					flg |= ev_flags(d[7:0], pre);
				end
				2:
				begin
					wb(1'b1, s[4] ? ADDR_IRQ_STAT : ADDR_STATUS, s[4] ? 4'h1 : 4'h8, d, q, e);
					flg &= s[4] ? ~d[5:0] : ~{d[31:27], d[24]};
				end
				default:
				begin
					wb(1'b1, ADDR_IRQ_MASK, 4'h1, d, q, e);
					msk = d[5:0];
					wb(1'b1, ADDR_BRCTL, 4'h4, s, q, e);
					pre = s[16];
				end
			endcase
			check_state();
		end
		// a reset in mid-run brings every register back to its reset value
		@(posedge clk_sys);
		reset_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		reset_n <= 1'b1;
		{flg, msk, pre, base, lim} = '0;
		check_state();
		// an event in the very cycle its flag is cleared keeps the flag set
		fork
			fire_ev(8'h01);
			begin
				@(posedge clk_sys);
				wb(1'b1, ADDR_IRQ_STAT, 4'h1, 32'h20, q, e);
			end
		join
		flg[5] = 1'b1;
		check_state();
		conclude();
	end
endmodule
